/* File: rtl/acvs_pkg.sv */
// Package for the converter cycle sequencer: register map, field positions, states.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
package acvs_pkg;
    // Register byte offsets
    localparam logic [7:0] ACVS_CTRL0_OFS  = 8'h00; // converter_control_0
    localparam logic [7:0] ACVS_CTRL1_OFS  = 8'h04; // converter_control_1
    localparam logic [7:0] ACVS_PRE_OFS    = 8'h08; // precharge length
    localparam logic [7:0] ACVS_ACQ_OFS    = 8'h0C; // acquisition_count
    localparam logic [7:0] ACVS_PUMP_OFS   = 8'h10; // pump_control
    localparam logic [7:0] ACVS_STAT_OFS   = 8'h14; // status
    localparam logic [7:0] ACVS_CLKDIV_OFS = 8'h18; // converter clock divider
    // converter_control_0 bits
    localparam int ACVS_C0_ON    = 0;
    localparam int ACVS_C0_GO    = 1;
    localparam int ACVS_C0_CONTINUOUS_CONVERSION  = 2;
    localparam int ACVS_C0_DSEN  = 3; // double sample (differential)
    localparam int ACVS_C0_RCSEL = 4; // dedicated oscillator as converter clock
    // converter_control_1 bits
    localparam int ACVS_C1_PPOL  = 0; // charge_polarity_select
    localparam int ACVS_C1_GPOL  = 1; // guard_polarity
    localparam int ACVS_C1_GINV  = 2; // guard_invert_second_sample
    // pump_control bits
    localparam int ACVS_P_EN     = 0;
    localparam int ACVS_P_RDY    = 1;
    // status bits
    localparam int ACVS_S_DONE   = 0; // conversion_done_flag, write 1 to clear
    localparam int ACVS_S_BUSY   = 1;
    localparam int ACVS_S_PHASE  = 4; // phase code at bits 6:4
    // Widths and fixed counts
    localparam int ACVS_CNT_W = 13;
    localparam logic [12:0] ACVS_ACQ_MAX = 13'h1FFF; // 8191 converter clocks
    localparam logic [12:0] ACVS_CNT_ONE = 13'h0001;
    localparam logic [12:0] ACVS_CNT_ZERO = 13'h0000;
    localparam logic [7:0] ACVS_CONV_TAD = 8'h0F; // converter clocks per conversion
    localparam logic [15:0] ACVS_PUMP_TAD = 16'h0100; // pump start-up, converter clocks
    localparam logic [1:0] AXI_OKAY   = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    typedef enum logic [2:0]
    {
        ACVS_IDLE = 3'b000,
        ACVS_PRE  = 3'b001,
        ACVS_ACQ  = 3'b010,
        ACVS_CONV = 3'b011
    } acvs_state_type;
endpackage

/* File: rtl/acvs_seq.sv */
// Conversion cycle sequencer with precharge, acquisition, guard outputs and pump readiness.
// Assumes an AXI4-Lite master on CLK_SYS; trigger and restart come from same-clock logic.
`timescale 1ns/1ns
module acvs_seq
    import acvs_pkg::*;
#(
    parameter int DIV_W = 8
)
(
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    // Converter clock tick from dedicated oscillator domain (asynchronous)
    input  wire logic              RC_TICK,
    // Hardware start sources
    input  wire logic              TRIG,
    input  wire logic              RESTART,
    // AXI4-Lite write address
    input  wire logic [7:0]        S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [7:0]        S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // Analog front end controls
    output logic                   HOLD_PRECHARGE,
    output logic                   HOLD_TO_SUPPLY,
    output logic                   HOLD_CONNECT,
    output logic                   PIN_DRIVE_OUT,
    output logic                   PIN_DRIVE_OE_N,
    output logic                   CONVERT_ACTIVE,
    output logic                   GUARD_OUT_A,
    output logic                   GUARD_OUT_B,
    output logic                   CONVERSION_DONE_FLAG,
    output logic                   PUMP_ON
);
    initial
    begin
        if (DIV_W < 1 || DIV_W > 16)
            $error("DIV_W out of range");
    end

    // Software registers
    logic [4:0]           ctrl0_r;
    logic [2:0]           ctrl1_r;
    logic [12:0]          pre_len_r;
    logic [12:0]          acq_cnt_r;
    logic                 pump_en_r;
    logic                 pump_rdy_r;
    logic                 done_r;
    logic [DIV_W-1:0]     clkdiv_r;
    // Sequencer state
    acvs_state_type       state_r;
    logic [12:0]          cnt_r;
    logic                 second_r;
    logic                 ga_r;
    logic                 gb_r;
    logic [DIV_W-1:0]     div_r;
    logic [15:0]          pump_cnt_r;
    logic [2:0]           rc_sync_r;
    logic                 rc_prev_r;
    // Bus slave state
    logic                 aw_r;
    logic                 w_r;
    logic [7:0]           awaddr_r;
    logic [31:0]          wdata_r;
    logic [3:0]           wstrb_r;
    logic                 bvalid_r;
    logic [1:0]           bresp_r;
    logic                 rvalid_r;
    logic [31:0]          rdata_r;
    logic [1:0]           rresp_r;

    // Offset decode, used for both reads and writes
    function automatic logic ofs_ok(input logic [7:0] a);
        ofs_ok = (a == ACVS_CTRL0_OFS) || (a == ACVS_CTRL1_OFS) || (a == ACVS_PRE_OFS) ||
                 (a == ACVS_ACQ_OFS) || (a == ACVS_PUMP_OFS) || (a == ACVS_STAT_OFS) ||
                 (a == ACVS_CLKDIV_OFS);
    endfunction

    // Write path: address and data latched independently, committed together
    wire wr_go   = aw_r && w_r && !bvalid_r;
    wire wr_c0   = wr_go && (awaddr_r == ACVS_CTRL0_OFS) && wstrb_r[0];
    wire wr_c1   = wr_go && (awaddr_r == ACVS_CTRL1_OFS) && wstrb_r[0];
    wire wr_pre  = wr_go && (awaddr_r == ACVS_PRE_OFS);
    wire wr_acq  = wr_go && (awaddr_r == ACVS_ACQ_OFS);
    wire wr_pump = wr_go && (awaddr_r == ACVS_PUMP_OFS) && wstrb_r[0];
    wire wr_stat = wr_go && (awaddr_r == ACVS_STAT_OFS) && wstrb_r[0];
    wire wr_div  = wr_go && (awaddr_r == ACVS_CLKDIV_OFS) && wstrb_r[0];
    wire [12:0] wr13 = {wstrb_r[1] ? wdata_r[12:8] : 5'h00, wstrb_r[0] ? wdata_r[7:0] : 8'h00};

    // Converter clock tick: divided system clock or synchronised oscillator edge
    wire rc_edge  = rc_sync_r[2] && rc_sync_r[1] && !rc_prev_r;
    wire div_tick = (div_r == clkdiv_r);
    wire tad      = ctrl0_r[ACVS_C0_RCSEL] ? rc_edge : div_tick;

    // Sequence decisions
    wire on        = ctrl0_r[ACVS_C0_ON];
    wire go_sw     = wr_c0 && wdata_r[ACVS_C0_GO];
    wire start     = on && (state_r == ACVS_IDLE) &&
                     (ctrl0_r[ACVS_C0_GO] || TRIG || RESTART);
    wire pre_on    = (pre_len_r != ACVS_CNT_ZERO);
    wire [12:0] acq_load = (acq_cnt_r == ACVS_CNT_ZERO) ? ACVS_ACQ_MAX : acq_cnt_r;
    wire cnt_end   = tad && (cnt_r == ACVS_CNT_ONE);
    wire conv_end  = (state_r == ACVS_CONV) && cnt_end;
    wire dsen      = ctrl0_r[ACVS_C0_DSEN];
    wire again     = conv_end && dsen && !second_r;
    wire finish    = conv_end && !again;
    wire ppol_eff  = ctrl1_r[ACVS_C1_PPOL] ^ second_r;
    wire g_second  = second_r && ctrl1_r[ACVS_C1_GINV];
    wire gpol_eff  = ctrl1_r[ACVS_C1_GPOL] ^ g_second;

    // Entry into the next phase after a start or after the first sample
    wire enter     = start || again;
    wire enter_pre = enter && pre_on;
    wire enter_acq = (enter && !pre_on && (acq_cnt_r != ACVS_CNT_ZERO)) ||
                     ((state_r == ACVS_PRE) && cnt_end);
    wire enter_cnv = (enter && !pre_on && (acq_cnt_r == ACVS_CNT_ZERO)) ||
                     ((state_r == ACVS_ACQ) && cnt_end);

    // Next state and counter
    acvs_state_type state_nxt;
    logic [12:0]    cnt_nxt;
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (!on)
            state_nxt = ACVS_IDLE;
        else if (enter_pre)
        begin
            state_nxt = ACVS_PRE;
            cnt_nxt   = pre_len_r;
        end
        else if (enter_acq)
        begin
            state_nxt = ACVS_ACQ;
            cnt_nxt   = pre_on ? acq_load : acq_cnt_r;
        end
        else if (enter_cnv)
        begin
            state_nxt = ACVS_CONV;
            cnt_nxt   = {5'h00, ACVS_CONV_TAD};
        end
        else if (finish)
            state_nxt = ACVS_IDLE;
        else if (tad && (state_r != ACVS_IDLE))
            cnt_nxt = cnt_r - ACVS_CNT_ONE;
    end

    // Sequencer registers
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            state_r  <= ACVS_IDLE;
            cnt_r    <= ACVS_CNT_ZERO;
            second_r <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            cnt_r    <= cnt_nxt;
            second_r <= on && (again || (second_r && !finish && !start));
        end
    end

    // Guard outputs; idle holds last level so the pattern is continuous
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ga_r <= 1'b0;
            gb_r <= 1'b0;
        end
        else if (enter_pre)
        begin
            ga_r <= ctrl1_r[ACVS_C1_GPOL] ^ (again && ctrl1_r[ACVS_C1_GINV]);
            gb_r <= ctrl1_r[ACVS_C1_GPOL] ^ (again && ctrl1_r[ACVS_C1_GINV]);
        end
        else if (enter_acq)
            ga_r <= ~gpol_eff;
    end

    // Converter clock generation and pin-side tick synchroniser (three stages)
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            div_r     <= '0;
            rc_sync_r <= 3'b000;
            rc_prev_r <= 1'b0;
        end
        else
        begin
            div_r     <= div_tick ? '0 : div_r + 1'b1;
            rc_sync_r <= {rc_sync_r[1:0], RC_TICK};
            if (rc_sync_r[2] == rc_sync_r[1])
                rc_prev_r <= rc_sync_r[2];
        end
    end

    // Charge pump start-up timer
    always_ff @(posedge CLK_SYS)
    begin
        if (RST || !pump_en_r)
        begin
            pump_cnt_r <= 16'h0000;
            pump_rdy_r <= 1'b0;
        end
        else if (tad && !pump_rdy_r)
        begin
            pump_cnt_r <= pump_cnt_r + 16'h0001;
            pump_rdy_r <= (pump_cnt_r == ACVS_PUMP_TAD - 16'h0001);
        end
    end

    // Software registers; hardware events win over software clears
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            ctrl0_r   <= 5'h00;
            ctrl1_r   <= 3'h0;
            pre_len_r <= 13'h0000;
            acq_cnt_r <= 13'h0000;
            pump_en_r <= 1'b0;
            done_r    <= 1'b0;
            clkdiv_r  <= '0;
        end
        else
        begin
            if (wr_c0)
                ctrl0_r <= wdata_r[4:0];
            else if (finish && !ctrl0_r[ACVS_C0_CONTINUOUS_CONVERSION])
                ctrl0_r[ACVS_C0_GO] <= 1'b0;
            if (wr_c1)
                ctrl1_r <= wdata_r[2:0];
            if (wr_pre)
                pre_len_r <= wr13;
            if (wr_acq)
                acq_cnt_r <= wr13;
            if (wr_pump)
                pump_en_r <= wdata_r[ACVS_P_EN];
            if (wr_div)
                clkdiv_r <= wdata_r[DIV_W-1:0];
            if (finish)
                done_r <= 1'b1;
            else if (wr_stat && wdata_r[ACVS_S_DONE])
                done_r <= 1'b0;
        end
    end

    // Read data mux
    wire [31:0] rd_mux =
        (S_AXI_ARADDR == ACVS_CTRL0_OFS)  ? {27'h0, ctrl0_r} :
        (S_AXI_ARADDR == ACVS_CTRL1_OFS)  ? {29'h0, ctrl1_r} :
        (S_AXI_ARADDR == ACVS_PRE_OFS)    ? {19'h0, pre_len_r} :
        (S_AXI_ARADDR == ACVS_ACQ_OFS)    ? {19'h0, acq_cnt_r} :
        (S_AXI_ARADDR == ACVS_PUMP_OFS)   ? {30'h0, pump_rdy_r, pump_en_r} :
        (S_AXI_ARADDR == ACVS_STAT_OFS)   ? {25'h0, state_r, 2'b00, second_r, done_r} :
        (S_AXI_ARADDR == ACVS_CLKDIV_OFS) ? {{(32-DIV_W){1'b0}}, clkdiv_r} : 32'h0;

    // AXI4-Lite handshake; go_sw is decoded only through the register write
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= AXI_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= AXI_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_r <= 1'b1;
                awaddr_r <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_r <= 1'b1;
                wdata_r <= S_AXI_WDATA;
                wstrb_r <= S_AXI_WSTRB;
            end
            if (wr_go)
            begin
                aw_r <= 1'b0;
                w_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= ofs_ok(awaddr_r) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (S_AXI_BREADY)
                bvalid_r <= 1'b0;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= ofs_ok(S_AXI_ARADDR) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (S_AXI_RREADY)
                rvalid_r <= 1'b0;
        end
    end

    // Bus outputs
    assign S_AXI_AWREADY = !aw_r && !bvalid_r;
    assign S_AXI_WREADY  = !w_r && !bvalid_r;
    assign S_AXI_BVALID  = bvalid_r;
    assign S_AXI_BRESP   = bresp_r;
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID  = rvalid_r;
    assign S_AXI_RDATA   = rdata_r;
    assign S_AXI_RRESP   = rresp_r;

    // Analog controls; hold capacitor is precharged to supply or discharged, as ppol_eff selects
    assign HOLD_PRECHARGE = (state_r == ACVS_PRE);
    assign HOLD_TO_SUPPLY = ppol_eff;
    assign PIN_DRIVE_OUT  = ~ppol_eff;
    assign PIN_DRIVE_OE_N = (state_r != ACVS_PRE);
    assign HOLD_CONNECT   = (state_r == ACVS_ACQ);
    assign CONVERT_ACTIVE = (state_r == ACVS_CONV);
    assign GUARD_OUT_A    = ga_r;
    assign GUARD_OUT_B    = gb_r;
    assign CONVERSION_DONE_FLAG = done_r;
    assign PUMP_ON        = pump_en_r;

    wire unused_ok = go_sw;
endmodule

/* File: sim/acvs_seq_properties.sv */
// Port checker for the converter cycle sequencer.
// Assumes one clock, CLK_SYS, with RST synchronous and active high.
`timescale 1ns/1ns
module acvs_seq_checker
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST,
    // Front end controls
    input wire logic HOLD_PRECHARGE,
    input wire logic HOLD_TO_SUPPLY,
    input wire logic HOLD_CONNECT,
    input wire logic PIN_DRIVE_OUT,
    input wire logic PIN_DRIVE_OE_N,
    input wire logic CONVERT_ACTIVE,
    input wire logic GUARD_OUT_A,
    input wire logic GUARD_OUT_B,
    input wire logic CONVERSION_DONE_FLAG
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // Pin override exists only while precharging
    chk_pin_drive: assert property (HOLD_PRECHARGE |-> !PIN_DRIVE_OE_N)
        else $error("pin not driven during precharge");
    chk_pin_release: assert property (!HOLD_PRECHARGE |-> PIN_DRIVE_OE_N)
        else $error("pin driven outside precharge");
    chk_pin_opposite: assert property (HOLD_PRECHARGE |-> PIN_DRIVE_OUT != HOLD_TO_SUPPLY)
        else $error("pin level not opposite to hold rail");
    // Hold rail must not flip inside one precharge
    chk_rail_steady: assert property (HOLD_PRECHARGE && $past(HOLD_PRECHARGE)
        |-> $stable(HOLD_TO_SUPPLY))
        else $error("hold rail changed within precharge");
    chk_phase_onehot: assert property (
        $onehot0({HOLD_PRECHARGE, HOLD_CONNECT, CONVERT_ACTIVE}))
        else $error("two phases active at once");
    // Leaving precharge for acquisition flips guard A and leaves guard B alone
    chk_guard_a_flip: assert property ($fell(HOLD_PRECHARGE)
        |-> GUARD_OUT_A != $past(GUARD_OUT_A))
        else $error("guard A did not flip at acquisition");
    chk_guard_b_hold: assert property ($fell(HOLD_PRECHARGE)
        |-> $stable(GUARD_OUT_B))
        else $error("guard B moved at acquisition");
    // Phase order: precharge, acquisition, conversion, done
    chk_acq_after_pre: assert property ($fell(HOLD_PRECHARGE) |-> HOLD_CONNECT)
        else $error("acquisition did not follow precharge");
    chk_conv_after_acq: assert property ($fell(HOLD_CONNECT) |-> CONVERT_ACTIVE)
        else $error("conversion did not follow acquisition");
    chk_done_after_conv: assert property ($fell(CONVERT_ACTIVE) && !HOLD_PRECHARGE && !HOLD_CONNECT
        |-> ##[0:1] CONVERSION_DONE_FLAG)
        else $error("done flag missing after conversion");
endmodule

bind acvs_seq acvs_seq_checker i_acvs_seq_checker (.CLK_SYS(CLK_SYS), .RST(RST),
    .HOLD_PRECHARGE(HOLD_PRECHARGE), .HOLD_TO_SUPPLY(HOLD_TO_SUPPLY),
    .HOLD_CONNECT(HOLD_CONNECT), .PIN_DRIVE_OUT(PIN_DRIVE_OUT),
    .PIN_DRIVE_OE_N(PIN_DRIVE_OE_N), .CONVERT_ACTIVE(CONVERT_ACTIVE),
    .GUARD_OUT_A(GUARD_OUT_A), .GUARD_OUT_B(GUARD_OUT_B),
    .CONVERSION_DONE_FLAG(CONVERSION_DONE_FLAG));

/* File: sim/acvs_sensor_model.sv */
// Capacitive sensor node on the analog channel pin.
// Assumes the pin override pair from the sequencer, same clock.
`timescale 1ns/1ns
module acvs_sensor_model
(
    // Clock
    input wire logic clk,
    // Pin override
    input wire logic pin_out,
    input wire logic pin_oe_n,
    // Sensor node level
    output logic     sensor_node
);
    // Sensor cap holds its charge once released; no pull on the node
    always_ff @(posedge clk)
    begin
        if (!pin_oe_n)
            sensor_node <= pin_out;
    end
endmodule

/* File: sim/test_acvs_seq.sv */
// Self-checking bench for the converter cycle sequencer.
// Assumes converter clock divider at reset value 0: one tick per CLK_SYS cycle.
`timescale 1ns/1ns
module test_acvs_seq;
    import acvs_pkg::*;
    typedef struct {logic [12:0] pre; logic [12:0] acq; logic ppol; logic continuous_conversion; int n_acq;}
        acvs_row_type;
    logic CLK_SYS = 1'b0, RST = 1'b1, TRIG = 1'b0, RESTART = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, cprev = 0;
    logic awrdy, wrdy, bvalid, arrdy, rvalid, pre_on, hts_o, hconn, pout, poe_n, conv, ga, gb;
    logic done_f, sensor_node, k, pump_on, rc_tick = 1'b0, rc_ph = 1'b0;
    logic [1:0] bresp, rresp, r, g_pre[2], g_acq[2];
    logic [31:0] rdata;
    logic hts[2], sens[2];
    int failures = 0, checked = 0, cycles = 0, pre_n, acq_n, conv_n;
    acvs_row_type rows[5] = '{'{13'h0003, 13'h0004, 1'b0, 1'b0, 4},
        '{13'h0001, 13'h0001, 1'b1, 1'b0, 1}, '{13'h0000, 13'h0005, 1'b0, 1'b0, 5},
        '{13'h0000, 13'h0000, 1'b0, 1'b1, 0}, '{13'h0002, 13'h0000, 1'b1, 1'b0, 8191}};

    acvs_seq i_acvs_seq (.CLK_SYS(CLK_SYS), .RST(RST), .RC_TICK(rc_tick), .TRIG(TRIG),
        .RESTART(RESTART), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .HOLD_PRECHARGE(pre_on), .HOLD_TO_SUPPLY(hts_o), .HOLD_CONNECT(hconn),
        .PIN_DRIVE_OUT(pout), .PIN_DRIVE_OE_N(poe_n), .CONVERT_ACTIVE(conv),
        .GUARD_OUT_A(ga), .GUARD_OUT_B(gb), .CONVERSION_DONE_FLAG(done_f), .PUMP_ON(pump_on));
    acvs_sensor_model i_acvs_sensor_model (.clk(CLK_SYS), .pin_out(pout), .pin_oe_n(poe_n),
        .sensor_node(sensor_node));

    always #10 CLK_SYS = ~CLK_SYS;

    // Free-running oscillator tick, one rising edge every four system cycles
    always @(posedge CLK_SYS)
    begin
        rc_ph <= ~rc_ph;
        if (rc_ph) rc_tick <= ~rc_tick;
    end

    // Phase monitor at the falling edge, where everything is settled
    always @(negedge CLK_SYS)
    begin
        // Sample index moves first, so the second precharge lands in slot 1
        if (!conv && cprev) k = ~k;
        cprev = conv;
        if (pre_on) begin pre_n++; hts[k] = hts_o; g_pre[k] = {ga, gb}; end
        if (hconn) begin acq_n++; sens[k] = sensor_node; g_acq[k] = {ga, gb}; end
        if (conv) conv_n++;
    end

    // Hang guard; longest case is the 8191-tick acquisition
    always @(posedge CLK_SYS)
    begin
        cycles++;
        if (cycles == 40000) begin failures++; end_sim; end
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task end_sim;
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Write: address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic ah, wh, bh;
        @(posedge CLK_SYS);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        bh = 1'b0;
        while (!bh)
        begin
            @(negedge CLK_SYS);
            ah = awvalid && awrdy; wh = wvalid && wrdy; bh = bvalid;
            @(posedge CLK_SYS);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ah, rh;
        @(posedge CLK_SYS);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        rh = 1'b0;
        while (!rh)
        begin
            @(negedge CLK_SYS);
            ah = arvalid && arrdy; rh = rvalid; v = rdata; rs = rresp;
            @(posedge CLK_SYS);
            if (ah) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task clr;
        pre_n = 0; acq_n = 0; conv_n = 0; k = 1'b0;
    endtask

    // Poll the status word until a bit reads as wanted
    task wait_stat(input int bitn, input logic want);
        d = ~32'h0;
        d[bitn] = ~want;
        while (d[bitn] !== want) rd(ACVS_STAT_OFS, d, r);
    endtask

    initial
    begin
        repeat (20) @(posedge CLK_SYS);
        RST <= 1'b0;
        @(posedge CLK_SYS);
        check("oe_n", poe_n, 1);
        check("guards", {ga, gb}, 0);
        rd(ACVS_CTRL0_OFS, d, r);
        check("ctrl0", d, 0);
        // Ordinary conversions, one per row; the continuous row repeats while GO stays set
        foreach (rows[i])
        begin
            wr(ACVS_PRE_OFS, {19'h0, rows[i].pre});
            wr(ACVS_ACQ_OFS, {19'h0, rows[i].acq});
            wr(ACVS_CTRL1_OFS, {31'h0, rows[i].ppol});
            clr;
            if (rows[i].pre == 0 && rows[i].acq == 0) repeat (8) @(posedge CLK_SYS);
            wr(ACVS_CTRL0_OFS, {29'h0, rows[i].continuous_conversion, 2'b11});
            wait_stat(ACVS_S_DONE, 1'b1);
            rd(ACVS_CTRL0_OFS, d, r);
            check("go", d[ACVS_C0_GO], rows[i].continuous_conversion);
            if (!rows[i].continuous_conversion)
            begin
                check("pre_len", pre_n, rows[i].pre);
                check("acq_len", acq_n, rows[i].n_acq);
                check("conv_len", conv_n, ACVS_CONV_TAD);
                if (rows[i].pre != 0) check("rail", hts[0], rows[i].ppol);
                if (rows[i].pre != 0) check("sensor", sens[0], !rows[i].ppol);
            end
            wr(ACVS_CTRL0_OFS, 32'h1);
            // Wait for the phase field to read idle
            d = ~32'h0;
            while (d[ACVS_S_PHASE +: 3] !== 3'b000) rd(ACVS_STAT_OFS, d, r);
            wr(ACVS_STAT_OFS, 32'h1);
            rd(ACVS_STAT_OFS, d, r);
            check("done_clr", d[ACVS_S_DONE], 0);
        end
        // Hardware trigger and computation restart
        wr(ACVS_PRE_OFS, 32'h2);
        wr(ACVS_ACQ_OFS, 32'h2);
        for (int j = 0; j < 2; j++)
        begin
            clr;
            @(posedge CLK_SYS);
            if (j == 0) TRIG <= 1'b1; else RESTART <= 1'b1;
            @(posedge CLK_SYS);
            TRIG <= 1'b0; RESTART <= 1'b0;
            wait_stat(ACVS_S_DONE, 1'b1);
            check("hw_pre", pre_n, 2);
            wr(ACVS_STAT_OFS, 32'h1);
        end
        // Double sample with guard inversion
        wr(ACVS_CTRL1_OFS, 32'h6);
        clr;
        wr(ACVS_CTRL0_OFS, 32'hB);
        wait_stat(ACVS_S_DONE, 1'b1);
        check("dbl_pre", pre_n, 4);
        check("dbl_conv", conv_n, 2 * ACVS_CONV_TAD);
        check("rail1", {hts[0], hts[1]}, 2'b01);
        check("sens", {sens[0], sens[1]}, 2'b10);
        check("g_pre1", g_pre[0], 2'b11);
        check("g_acq1", g_acq[0], 2'b01);
        check("g_pre2", g_pre[1], 2'b00);
        check("g_acq2", g_acq[1], 2'b10);
        // Oscillator as converter clock: two ticks of precharge span 5 to 8 cycles
        wr(ACVS_STAT_OFS, 32'h1);
        clr;
        wr(ACVS_CTRL0_OFS, 32'h13);
        wait_stat(ACVS_S_DONE, 1'b1);
        check("rc_pre", (pre_n > 4) && (pre_n < 9), 1);
        wr(ACVS_CTRL0_OFS, 32'h1);
        // Pump start-up and an unmapped read
        wr(ACVS_PUMP_OFS, 32'h1);
        check("pump_on", pump_on, 1);
        repeat (200) @(posedge CLK_SYS);
        rd(ACVS_PUMP_OFS, d, r);
        check("rdy_early", d[ACVS_P_RDY], 0);
        repeat (70) @(posedge CLK_SYS);
        rd(ACVS_PUMP_OFS, d, r);
        check("rdy_late", d[ACVS_P_RDY], 1);
        rd(8'h40, d, r);
        check("unmapped", d, 32'h0);
        check("slverr", r, AXI_SLVERR);
        end_sim;
    end
endmodule
